//--- inc/sgc_defines.svh
`ifndef SGC_DEFINES_SVH
`define SGC_DEFINES_SVH

// Register indices and byte addresses (index times four)
`define SGC_IDX_LANE_CTRL 12'h608
`define SGC_IDX_EEE_TIMER 12'h609
`define SGC_IDX_LINK_STAT 12'h60A
`define SGC_IDX_QUIET_TMR 12'h60B
`define SGC_IDX_INT_STAT 12'h610
`define SGC_IDX_INT_MASK 12'h611
`define SGC_ADDR_W 14
`define SGC_BYTE_ADDR(idx) ({idx, 2'h0})

// Reset values
`define SGC_RST_LANE_CTRL 16'h007B
`define SGC_RST_EEE_TIMER 16'h6318
`define SGC_RST_QUIET_TMR 16'h0005

// Lane control fields
`define SGC_LC_ERR_DIS 15
`define SGC_LC_IDX_FORCE 14
`define SGC_LC_IDX_HI 13
`define SGC_LC_IDX_LO 10
`define SGC_LC_SGMII_EN 9
`define SGC_LC_RX_POL 8
`define SGC_LC_TX_POL 7
`define SGC_LC_IN_ORD_HI 6
`define SGC_LC_IN_ORD_LO 5
`define SGC_LC_OUT_ORD 4
`define SGC_LC_PKT_ALIGN 3
`define SGC_LC_TMR_HI 2
`define SGC_LC_TMR_LO 1
`define SGC_LC_AN_EN 0

// Status fields
`define SGC_ST_PAGE 12
`define SGC_ST_LINK 11
`define SGC_ST_DONE 10
`define SGC_ST_ALIGN 9
`define SGC_ST_SYNC 8

// Interrupt bits
`define SGC_IRQ_PAGE 0
`define SGC_IRQ_LINK 1
`define SGC_IRQ_DONE 2
`define SGC_IRQ_SYNC 3
`define SGC_IRQ_W 4

// Timing: link timer choices in microseconds, clock period in ns
`define SGC_CLK_NS 10
`define SGC_AN_T0_US 1600
`define SGC_AN_T1_US 2
`define SGC_AN_T2_US 800
`define SGC_AN_T3_US 11000
`define SGC_US_TO_CYC(us) ((us) * 1000 / `SGC_CLK_NS)

// Comma patterns in first-received bit order, and confirm count
`define SGC_COMMA_POS 7'b1111100
`define SGC_COMMA_NEG 7'b0000011
`define SGC_CONFIRM_CNT 2'h3

`endif

//--- inc/sgc_pkg.sv
package sgc_pkg;

    typedef enum logic [3:0] {
        SGC_SEARCH = 4'b0001,
        SGC_CONFIRM = 4'b0010,
        SGC_LOCKED = 4'b0100,
        SGC_GUARD = 4'b1000
    } sgc_wb_state_t;

endpackage : sgc_pkg

//--- rtl/sgc_word_align.sv
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.svh"

module sgc_word_align
    import sgc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Ordered comma-detect bus
    input wire logic [19:0] cd_bus,
    // Index override
    input wire logic idx_force,
    input wire logic [3:0] idx_value,
    // Alignment results
    output logic sync_ok,
    output logic align_hit,
    output logic [3:0] cur_idx,
    output logic [3:0] cur_state,
    output logic [9:0] aligned_group
);

    sgc_wb_state_t state_q;
    logic [3:0] found_q;
    logic [1:0] cnt_q;
    logic [3:0] use_idx;
    logic [3:0] first_hit;
    logic hit;
    logic [9:0] win;

    function automatic logic is_comma(input logic [9:0] g);
        is_comma = (g[6:0] == `SGC_COMMA_POS) || (g[6:0] == `SGC_COMMA_NEG);
    endfunction : is_comma

    function automatic logic [9:0] window(input logic [19:0] b, input logic [3:0] i);
        window = 10'((b >> i));
    endfunction : window

    assign use_idx = (idx_force && idx_value <= 4'h9) ? idx_value : found_q;
    assign win = window(cd_bus, use_idx);
    assign hit = is_comma(win);

    always_comb begin
        first_hit = found_q;
        for (int i = 9; i >= 0; i--) begin
            if (is_comma(window(cd_bus, 4'(i)))) begin
                first_hit = 4'(i);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= SGC_SEARCH;
            found_q <= 4'h0;
            cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                SGC_SEARCH: begin
                    cnt_q <= 2'h0;
                    if (idx_force ? hit : is_comma(window(cd_bus, first_hit))) begin
                        found_q <= first_hit;
                        state_q <= SGC_CONFIRM;
                    end
                end
                SGC_CONFIRM: begin
                    if (hit) begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q + 2'h1 == `SGC_CONFIRM_CNT) begin
                            state_q <= SGC_LOCKED;
                        end
                    end else begin
                        state_q <= SGC_SEARCH;
                    end
                end
                SGC_LOCKED: begin
                    cnt_q <= 2'h0;
                    if (!hit) begin
                        state_q <= SGC_GUARD;
                    end
                end
                SGC_GUARD: begin
                    if (hit) begin
                        state_q <= SGC_LOCKED;
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                        if (cnt_q + 2'h1 == `SGC_CONFIRM_CNT) begin
                            state_q <= SGC_SEARCH;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            align_hit <= 1'b0;
            aligned_group <= 10'h000;
        end else begin
            align_hit <= hit;
            aligned_group <= win;
        end
    end

    assign sync_ok = (state_q == SGC_LOCKED) || (state_q == SGC_GUARD);
    assign cur_idx = use_idx;
    assign cur_state = state_q;

endmodule : sgc_word_align
`default_nettype wire

//--- rtl/sgc_sgmii_ctrl.sv
// Overview of operation
// - Receive polarity bit 8 set inverts incoming serial bus, else passes it.
// - Transmit polarity bit 7 set inverts outgoing serial bus.
// - Bits 6-5 pick bit order per group and half of 20-bit bus.
// - Bit 4 selects MSB-first or reversed order toward the serializer.
// - Bit 3 set starts each transmit packet on the even code-group pulse.
// - Bits 2-1 pick link timer: 1.6ms, 2us, 800us or 11ms.
// - Bit 0 enables auto-negotiation; reset leaves it enabled.
// - Energy control bit 0 enables compatibility mode for plain MACs.
// - Status bit 12 shows a new negotiation page was received.
// - Status bit 11 shows serial link up.
// - Status bit 10 shows negotiation completed.
// - Status bit 8 shows word-boundary sync achieved.
// - Status bit 9 shows the word-boundary align indication.
// - Status bits 7-4 show boundary index, bits 3-0 the machine state.
// - Force bit makes a programmed boundary index of 0 to 9 replace the found one.
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.svh"

module sgc_sgmii_ctrl
    import sgc_pkg::*;
#(
    parameter int unsigned AN_T0_CYC = `SGC_US_TO_CYC(`SGC_AN_T0_US),
    parameter int unsigned AN_T2_CYC = `SGC_US_TO_CYC(`SGC_AN_T2_US),
    parameter int unsigned AN_T3_CYC = `SGC_US_TO_CYC(`SGC_AN_T3_US)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SGC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Deserializer side
    input wire logic [19:0] des_bus,
    input wire logic partner_page,
    output logic [9:0] rx_group,
    // Serializer side
    input wire logic [9:0] tx_group,
    input wire logic tx_valid,
    input wire logic tx_start,
    input wire logic tx_even,
    output logic tx_ready,
    output logic [9:0] ser_group,
    // Lane and energy settings
    output logic sgmii_enable,
    output logic tx_err_disable,
    output logic negotiation_enable,
    output logic eee_compat_mode,
    output logic [4:0] lpi_transmit_refresh_time,
    output logic [4:0] lpi_transmit_quiet_time,
    output logic [4:0] lpi_transmit_sleep_time,
    output logic [3:0] rx_quiet_time,
    // Link state
    output logic serial_link_up,
    output logic negotiation_done
);

    localparam int unsigned AN_T1_CYC = `SGC_US_TO_CYC(`SGC_AN_T1_US);

    logic [15:0] lane_q;
    logic [15:0] eee_q;
    logic [3:0] quiet_q;
    logic [`SGC_IRQ_W-1:0] int_st_q;
    logic [`SGC_IRQ_W-1:0] int_mask_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic page_q;
    logic page_seen_q;
    logic done_q;
    logic [23:0] tmr_q;
    logic [23:0] tmr_lim;
    logic link_q;
    logic sync_q;
    logic in_pkt_q;
    logic [9:0] ser_q;
    logic [9:0] rxg_q;
    logic [19:0] rx_pol;
    logic [19:0] cd_bus;
    logic sync_ok;
    logic align_hit;
    logic [3:0] cur_idx;
    logic [3:0] cur_state;
    logic [9:0] aligned_group;
    logic [15:0] status_w;
    logic setup;
    logic access;
    logic wr_en;
    logic rd_en;
    logic [11:0] idx;
    logic hit_map;
    logic rd_stat;
    logic [`SGC_IRQ_W-1:0] ev;

    function automatic logic [9:0] rev10(input logic [9:0] g);
        for (int i = 0; i < 10; i++) begin
            rev10[i] = g[9 - i];
        end
    endfunction : rev10

    function automatic logic [15:0] wmask16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        wmask16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : wmask16

    // APB decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign idx = paddr[`SGC_ADDR_W-1:2];
    assign hit_map = (paddr[1:0] == 2'h0) &&
                     (idx == `SGC_IDX_LANE_CTRL || idx == `SGC_IDX_EEE_TIMER ||
                      idx == `SGC_IDX_LINK_STAT || idx == `SGC_IDX_QUIET_TMR ||
                      idx == `SGC_IDX_INT_STAT || idx == `SGC_IDX_INT_MASK);
    assign wr_en = access && pwrite && hit_map;
    assign rd_en = access && !pwrite && hit_map;
    assign rd_stat = rd_en && idx == `SGC_IDX_INT_STAT;
    assign pready = 1'b1;
    assign pslverr = access && err_q;
    assign prdata = rdata_q;

    assign status_w = {3'h0, page_q, link_q, done_q, align_hit, sync_q, cur_idx, cur_state};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= !hit_map;
            rdata_q <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (idx)
                    `SGC_IDX_LANE_CTRL: rdata_q <= {16'h0000, lane_q};
                    `SGC_IDX_EEE_TIMER: rdata_q <= {16'h0000, eee_q};
                    `SGC_IDX_LINK_STAT: rdata_q <= {16'h0000, status_w};
                    `SGC_IDX_QUIET_TMR: rdata_q <= {28'h0000000, quiet_q};
                    `SGC_IDX_INT_STAT: rdata_q <= {28'h0000000, int_st_q};
                    `SGC_IDX_INT_MASK: rdata_q <= {28'h0000000, int_mask_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register writes; status register ignores writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lane_q <= `SGC_RST_LANE_CTRL;
            eee_q <= `SGC_RST_EEE_TIMER;
            quiet_q <= 4'(`SGC_RST_QUIET_TMR);
            int_mask_q <= '0;
        end else if (wr_en) begin
            unique case (idx)
                `SGC_IDX_LANE_CTRL: lane_q <= wmask16(lane_q, pwdata, pstrb);
                `SGC_IDX_EEE_TIMER: eee_q <= wmask16(eee_q, pwdata, pstrb);
                `SGC_IDX_QUIET_TMR: begin
                    if (pstrb[0]) begin
                        quiet_q <= pwdata[3:0];
                    end
                end
                `SGC_IDX_INT_MASK: begin
                    if (pstrb[0]) begin
                        int_mask_q <= pwdata[`SGC_IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign sgmii_enable = lane_q[`SGC_LC_SGMII_EN];
    assign tx_err_disable = lane_q[`SGC_LC_ERR_DIS];
    assign negotiation_enable = lane_q[`SGC_LC_AN_EN];
    assign eee_compat_mode = eee_q[0];
    assign lpi_transmit_refresh_time = eee_q[15:11];
    assign lpi_transmit_quiet_time = eee_q[10:6];
    assign lpi_transmit_sleep_time = eee_q[5:1];
    assign rx_quiet_time = quiet_q;

    assign rx_pol = lane_q[`SGC_LC_RX_POL] ? ~des_bus : des_bus;

    // Group bit order and half placement
    always_comb begin
        logic [9:0] g0;
        logic [9:0] g1;
        g0 = lane_q[`SGC_LC_IN_ORD_LO] ? rev10(rx_pol[9:0]) : rx_pol[9:0];
        g1 = lane_q[`SGC_LC_IN_ORD_LO] ? rev10(rx_pol[19:10]) : rx_pol[19:10];
        cd_bus = lane_q[`SGC_LC_IN_ORD_HI] ? {g0, g1} : {g1, g0};
    end

    sgc_word_align u_align (
        .core_clk(core_clk),
        .rst(rst),
        .cd_bus(cd_bus),
        .idx_force(lane_q[`SGC_LC_IDX_FORCE]),
        .idx_value(lane_q[`SGC_LC_IDX_HI:`SGC_LC_IDX_LO]),
        .sync_ok(sync_ok),
        .align_hit(align_hit),
        .cur_idx(cur_idx),
        .cur_state(cur_state),
        .aligned_group(aligned_group)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxg_q <= 10'h000;
        end else begin
            rxg_q <= aligned_group;
        end
    end
    assign rx_group = rxg_q;

    always_comb begin
        unique case (lane_q[`SGC_LC_TMR_HI:`SGC_LC_TMR_LO])
            2'h0: tmr_lim = 24'(AN_T0_CYC);
            2'h1: tmr_lim = 24'(AN_T1_CYC);
            2'h2: tmr_lim = 24'(AN_T2_CYC);
            2'h3: tmr_lim = 24'(AN_T3_CYC);
        endcase
    end

    // Negotiation progress
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tmr_q <= 24'h000000;
            page_seen_q <= 1'b0;
            done_q <= 1'b0;
        end else if (!negotiation_enable || !sync_q) begin
            tmr_q <= 24'h000000;
            page_seen_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (partner_page) begin
                page_seen_q <= 1'b1;
            end
            if (tmr_q < tmr_lim) begin
                tmr_q <= tmr_q + 24'h000001;
            end
            // Completion after timer with a page
            if (tmr_q >= tmr_lim && page_seen_q) begin
                done_q <= 1'b1;
            end
        end
    end

    // New page flag, set wins over read clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            page_q <= 1'b0;
        end else if (partner_page && negotiation_enable) begin
            page_q <= 1'b1;
        end else if (rd_en && idx == `SGC_IDX_LINK_STAT) begin
            page_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            sync_q <= sync_ok;
            link_q <= sync_q && (done_q || !negotiation_enable);
        end
    end
    assign serial_link_up = link_q;
    assign negotiation_done = done_q;

    // Interrupt events, set wins over read clear
    assign ev[`SGC_IRQ_PAGE] = partner_page && negotiation_enable;
    assign ev[`SGC_IRQ_LINK] = link_q != (sync_q && (done_q || !negotiation_enable));
    assign ev[`SGC_IRQ_DONE] = !done_q && negotiation_enable && sync_q &&
                               tmr_q >= tmr_lim && page_seen_q;
    assign ev[`SGC_IRQ_SYNC] = sync_q != sync_ok;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_st_q <= '0;
        end else begin
            int_st_q <= (rd_stat ? '0 : int_st_q) | ev;
        end
    end
    assign irq = |(int_st_q & int_mask_q);

    // Hold packet start until even slot
    assign tx_ready = !(lane_q[`SGC_LC_PKT_ALIGN] && tx_start && !in_pkt_q && !tx_even);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_pkt_q <= 1'b0;
            ser_q <= 10'h000;
        end else begin
            if (tx_valid && tx_ready) begin
                in_pkt_q <= 1'b1;
                ser_q <= (lane_q[`SGC_LC_OUT_ORD] ? rev10(tx_group) : tx_group) ^
                         {10{lane_q[`SGC_LC_TX_POL]}};
            end
            if (!tx_valid) begin
                in_pkt_q <= 1'b0;
            end
        end
    end
    assign ser_group = ser_q;

endmodule : sgc_sgmii_ctrl
`default_nettype wire

//--- tb/sgc_sgmii_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.svh"

module sgc_sgmii_ctrl_checker
    import sgc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [`SGC_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    // Transmit side
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [9:0] ser_group,
    // Settings and link state
    input wire logic negotiation_enable,
    input wire logic negotiation_done,
    input wire logic serial_link_up,
    input wire logic sgmii_enable,
    input wire logic eee_compat_mode,
    input wire logic [4:0] lpi_transmit_refresh_time,
    input wire logic [3:0] rx_quiet_time
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic mapped;
    assign mapped = paddr inside {14'h1820, 14'h1824, 14'h1828, 14'h182C, 14'h1840, 14'h1844};

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable;
    endsequence

    chk_apb_ready: assert property (apb_setup ##1 apb_access |-> pready)
        else $error("pready low in access phase");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    chk_err_unmapped: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_map_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed outside setup");
    chk_ser_hold: assert property (!(tx_valid && tx_ready) |=> $stable(ser_group))
        else $error("serializer group changed without accept");
    chk_reset_cfg: assert property ($fell(rst) |-> negotiation_enable && !sgmii_enable
        && !eee_compat_mode && lpi_transmit_refresh_time == 5'h0C && rx_quiet_time == 4'h5)
        else $error("settings wrong after reset");
    chk_reset_link: assert property ($fell(rst) |-> !serial_link_up && !negotiation_done
        && !irq && ser_group == 10'h000)
        else $error("state wrong after reset");
    chk_an_off: assert property (!negotiation_enable [*3] |-> !negotiation_done)
        else $error("negotiation done while disabled");
endmodule : sgc_sgmii_ctrl_checker

bind sgc_sgmii_ctrl sgc_sgmii_ctrl_checker u_chk (
    .core_clk, .rst, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .irq,
    .tx_valid, .tx_ready, .ser_group, .negotiation_enable, .negotiation_done,
    .serial_link_up, .sgmii_enable, .eee_compat_mode, .lpi_transmit_refresh_time,
    .rx_quiet_time
);
`default_nettype wire

//--- tb/sgc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none

module sgc_mac_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bench controls
    input wire logic link_on,
    input wire logic page_go,
    input wire logic pkt_go,
    // Receive stream
    output logic [19:0] des_bus,
    output logic partner_page,
    // Transmit stream
    input wire logic tx_ready,
    output logic [9:0] tx_group,
    output logic tx_valid,
    output logic tx_start,
    output logic tx_even,
    output logic start_even,
    output logic pkt_busy
);
    // Comma group that reads the same in either bit order
    localparam logic [9:0] COMMA_G = 10'h0FC;
    logic [2:0] cnt_q;

    // Commas when linked, else a pattern that never holds a comma
    always_ff @(posedge core_clk) begin
        if (rst || !link_on) begin
            des_bus <= (des_bus[0] === 1'b1) ? 20'hAAAAA : 20'h55555;
        end else begin
            des_bus <= {COMMA_G, COMMA_G};
        end
    end

    always_ff @(posedge core_clk) begin
        partner_page <= !rst && page_go;
        tx_even <= !rst && !tx_even;
    end

    // Packets of four groups, each held until accepted
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_valid <= 1'b0;
            tx_start <= 1'b0;
            tx_group <= 10'h155;
            cnt_q <= 3'h0;
            start_even <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            if (tx_start) begin
                start_even <= tx_even;
            end
            tx_start <= 1'b0;
            tx_group <= {tx_group[8:0], tx_group[9] ^ tx_group[6]};
            cnt_q <= cnt_q - 3'h1;
            tx_valid <= cnt_q != 3'h1;
        end else if (pkt_go && !tx_valid && tx_even) begin
            tx_valid <= 1'b1;
            tx_start <= 1'b1;
            cnt_q <= 3'h4;
        end
    end
    assign pkt_busy = tx_valid;
endmodule : sgc_mac_model
`default_nettype wire

//--- tb/sgmii_pcs_config_status_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.svh"

module sgmii_pcs_config_status_test
    import sgc_pkg::*;
;
    localparam logic [13:0] A_LANE = `SGC_BYTE_ADDR(`SGC_IDX_LANE_CTRL);
    localparam logic [13:0] A_EEE = `SGC_BYTE_ADDR(`SGC_IDX_EEE_TIMER);
    localparam logic [13:0] A_ST = `SGC_BYTE_ADDR(`SGC_IDX_LINK_STAT);
    localparam logic [13:0] A_QT = `SGC_BYTE_ADDR(`SGC_IDX_QUIET_TMR);
    localparam logic [13:0] A_INT = `SGC_BYTE_ADDR(`SGC_IDX_INT_STAT);
    localparam logic [13:0] A_MSK = `SGC_BYTE_ADDR(`SGC_IDX_INT_MASK);
    localparam int LIM [4] = '{50, 200, 40, 60};
    logic core_clk, rst, psel, penable, pwrite, pslverr, pready, irq, er;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rv, v;
    logic [3:0] pstrb, rx_quiet_time, idx;
    logic [19:0] des_bus;
    logic partner_page, tx_valid, tx_start, tx_even, tx_ready, start_even, pkt_busy;
    logic [9:0] rx_group, tx_group, ser_group, exp_q;
    logic sgmii_enable, tx_err_disable, negotiation_enable, eee_compat_mode;
    logic [4:0] lpi_transmit_refresh_time, lpi_transmit_quiet_time, lpi_transmit_sleep_time;
    logic serial_link_up, negotiation_done, link_on, page_go, pkt_go, acc_q;
    logic [15:0] lane;
    integer seed = 84818;
    int n_fail = 0;
    int checks = 0;
    int n;

    sgc_sgmii_ctrl #(.AN_T0_CYC(50), .AN_T2_CYC(40), .AN_T3_CYC(60)) dut (
        .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .irq, .des_bus, .partner_page, .rx_group, .tx_group,
        .tx_valid, .tx_start, .tx_even, .tx_ready, .ser_group, .sgmii_enable,
        .tx_err_disable, .negotiation_enable, .eee_compat_mode,
        .lpi_transmit_refresh_time, .lpi_transmit_quiet_time, .lpi_transmit_sleep_time,
        .rx_quiet_time, .serial_link_up, .negotiation_done
    );
    sgc_mac_model mac (
        .core_clk, .rst, .link_on, .page_go, .pkt_go, .des_bus, .partner_page,
        .tx_ready, .tx_group, .tx_valid, .tx_start, .tx_even, .start_even, .pkt_busy
    );

    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) n_fail++;
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic rd(input logic [13:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string what);
        apb(1'b0, a, 32'h0);
        cmp(rv & m, e & m, what);
    endtask : rd

    task automatic wl(input logic [15:0] val);
        lane = val;
        apb(1'b1, A_LANE, 32'(val));
    endtask : wl

    task automatic pg();
        page_go <= 1'b1;
        @(posedge core_clk);
        page_go <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : pg

    task automatic pkt();
        pkt_go <= 1'b1;
        for (n = 0; pkt_busy !== 1'b1 && n < 20; n++) @(posedge core_clk);
        if (pkt_busy !== 1'b1) n_fail++;
        pkt_go <= 1'b0;
        for (n = 0; pkt_busy !== 1'b0 && n < 40; n++) @(posedge core_clk);
        @(posedge core_clk);
    endtask : pkt

    function automatic logic [9:0] tx_exp(input logic [9:0] g);
        logic [9:0] b;
        b = lane[4] ? {<<{g}} : g;
        return lane[7] ? ~b : b;
    endfunction : tx_exp

    // Serializer output checked one cycle after each accept
    always @(posedge core_clk) begin
        if (acc_q) cmp(32'(ser_group), 32'(exp_q), "ser group");
        acc_q <= tx_valid && tx_ready && !rst;
        exp_q <= tx_exp(tx_group);
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #200000;
        n_fail++;
        complete_run();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, link_on, page_go, pkt_go, acc_q} = '0;
        pstrb = 4'hF;
        rst = 1'b1;
        lane = 16'h007B;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(A_LANE, 32'h7B, '1, "lane reset");
        rd(A_EEE, 32'h6318, '1, "eee reset");
        rd(A_QT, 32'h5, '1, "quiet reset");
        repeat (6) begin
            v = $random(seed);
            apb(1'b1, A_EEE, v);
            rd(A_EEE, {16'h0, v[15:0]}, '1, "eee rw");
            cmp(32'(eee_compat_mode), 32'(v[0]), "compat");
            cmp(32'({lpi_transmit_refresh_time, lpi_transmit_quiet_time,
                lpi_transmit_sleep_time}), 32'(v[15:1]), "lpi");
            apb(1'b1, A_QT, v);
            rd(A_QT, 32'(v[3:0]), '1, "quiet rw");
            cmp(32'(rx_quiet_time), 32'(v[3:0]), "quiet");
        end
        apb(1'b1, A_ST, 32'hFFFF);
        rd(A_ST, 32'h0, 32'hFFFFE000, "status ro");
        apb(1'b0, 14'h1830, 32'h0);
        cmp({rv[30:0], er}, 32'h1, "unmapped");
        apb(1'b1, 14'h1822, 32'h0);
        cmp(32'(er), 32'h1, "unaligned");
        rd(A_LANE, 32'h7B, '1, "lane kept");
        link_on <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wl(16'h0009 | 16'(k[0]) << 8 | 16'(k[0]) << 9 | 16'(k[2:1]) << 5 | 16'(k[0]) << 15);
            repeat (30) @(posedge core_clk);
            rd(A_ST, 32'h0100 | 32'(SGC_LOCKED), 32'h010F, "sync");
            cmp(32'(rx_group), k[0] ? 32'h303 : 32'h0FC, "rx group");
            cmp(32'({tx_err_disable, sgmii_enable}), 32'({2{k[0]}}), "lane out");
        end
        v = $random(seed);
        idx = 4'(v[7:0] % 8'd10);
        wl(16'h4009 | 16'(idx) << 10);
        repeat (10) @(posedge core_clk);
        rd(A_ST, 32'(idx) << 4, 32'h00F0, "forced idx");
        wl(16'h0009);
        link_on <= 1'b0;
        repeat (40) @(posedge core_clk);
        rd(A_ST, 32'h0, 32'h0D00, "no sync");
        link_on <= 1'b1;
        wl(16'h0008);
        repeat (30) @(posedge core_clk);
        cmp(32'(serial_link_up), 32'h1, "link no an");
        for (int t = 0; t < 4; t++) begin
            wl(16'h0008 | 16'(t) << 1);
            wl(16'h0009 | 16'(t) << 1);
            pg();
            repeat (LIM[t] - 12) @(posedge core_clk);
            cmp(32'(negotiation_done), 32'h0, "done early");
            for (n = 0; negotiation_done !== 1'b1 && n < 40; n++) @(posedge core_clk);
            cmp(32'(negotiation_done), 32'h1, "done");
            rd(A_ST, 32'h1C00, 32'h1C00, "page link done");
            rd(A_ST, 32'h0, 32'h1000, "page clear");
        end
        cmp(32'(irq), 32'h0, "irq masked");
        rd(A_INT, 32'h1, 32'h1, "int masked");
        apb(1'b1, A_MSK, 32'h1);
        pg();
        cmp(32'(irq), 32'h1, "irq set");
        rd(A_INT, 32'h1, 32'h1, "int page");
        cmp(32'(irq), 32'h0, "irq clear");
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            wl(16'h0001 | 16'(k[0]) << 3 | 16'(k[1]) << 7 | 16'(v[0]) << 4);
            pkt();
            cmp(32'(start_even), 32'(k[0]), "even start");
        end
        complete_run();
    end
endmodule : sgmii_pcs_config_status_test
`default_nettype wire
